// ---- hw/ics_command.v ----
// Purpose: Settings interpreter and service-request front for a lock-in instrument
// Assumes: Parser hands over decoded commands as one-cycle strobes
// Notes: Queries answer on resp_valid one cycle after the strobe
//
// How it works
// - request line and status bit 6 together
// - masked status bit raises request line
// - zero mask never raises request
// - host writes mask, mask governs requests
// - input kind codes 0 to 2
// - nonzero input kind forces current input
// - voltage configuration codes 0 to 3
// - input device and coupling take 0/1
// - full scale 1..27, low noise needs 7+
// - floating full-scale form read only
// - auto sensitivity 30-90%, auto measure adds phase
// - amplifier gain codes 0..9, 10 dB steps
// - auto gain flag 0 manual 1 auto
// - notch codes 0..3, line 60/50 Hz
// - sample rate codes 0 to 2 only
// - operating mode 0/1, zero at power-up
// - reference arrangement 0..2, dual means extended
// - reference source codes 0 to 2
// - harmonic 1..65535, 1 is fundamental
// - phase millidegrees within 360000, or degrees
// - status bit 0 done, bit 7 data
// - bits 1-4: bad command, param, unlock, overload
// - no parameter means report present value
`timescale 1ns/1ps
`include "ics_defines.vh"

module ics_command (
  input wire clk,
  input wire nrst,
  input wire cmd_valid,
  input wire [4:0] cmd_code,
  input wire cmd_has_param,
  input wire cmd_has_second,
  input wire cmd_float,
  input wire [31:0] cmd_param,
  input wire [31:0] cmd_param2,
  input wire resp_taken,
  input wire ref_unlock,
  input wire overload,
  input wire new_adc,
  input wire [6:0] magnitude_pct,
  input wire auto_phase_done,
  output reg resp_valid,
  output reg [31:0] resp_data,
  output reg [31:0] resp_data2,
  output reg resp_two,
  output reg [1:0] input_kind_select,
  output reg current_input,
  output reg [1:0] voltage_config_select,
  output reg input_device_select,
  output reg coupling_select,
  output reg [4:0] full_scale_code,
  output reg [3:0] amp_gain_code,
  output reg auto_gain,
  output reg [1:0] notch_filter_select,
  output reg notch_line_50hz,
  output reg [1:0] sample_rate_select,
  output reg op_mode,
  output reg [1:0] reference_arrangement,
  output reg extended_commands,
  output reg [1:0] reference_source_select,
  output reg [15:0] harmonic_number,
  output reg [31:0] reference_phase_value,
  output reg auto_phase_start,
  output reg busy,
  output reg srq,
  output reg [7:0] status_byte
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SENS = 3'b010;
  localparam ST_PHASE = 3'b100;

  reg [2:0] state;
  reg [7:0] request_mask;
  reg bad_cmd;
  reg param_err;
  reg done;
  reg measure_after;
  wire [7:0] status_raw;
  wire srq_int;
  wire [7:0] status_int;

  // Unsigned range check
  function in_range;
    input [31:0] value;
    input [31:0] low;
    input [31:0] high;
    begin
      in_range = (value >= low) && (value <= high);
    end
  endfunction

  wire [31:0] abs_phase;
  wire ln_ok;
  wire fs_ok;
  assign abs_phase = cmd_param[31] ? (~cmd_param + 32'h0000_0001) : cmd_param;
  assign ln_ok = (input_kind_select != `ICS_INPUT_KIND_LOW_NOISE) ||
                 (cmd_param[4:0] >= `ICS_FS_LN_MIN);
  assign fs_ok = in_range(cmd_param, `ICS_FS_MIN, `ICS_FS_MAX) && ln_ok;

  assign status_raw = {resp_valid, 1'b0, new_adc, overload, ref_unlock, param_err, bad_cmd, done};

  ics_srq u_srq (
    .clk(clk),
    .nrst(nrst),
    .status_raw(status_raw),
    .request_mask(request_mask),
    .srq(srq_int),
    .status_byte(status_int)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Output mirrors
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srq <= 1'b0;
      status_byte <= 8'h00;
      current_input <= 1'b0;
      extended_commands <= 1'b0;
      busy <= 1'b0;
    end else begin
      srq <= srq_int;
      status_byte <= status_int;
      current_input <= (input_kind_select != 2'h0);
      extended_commands <= (reference_arrangement != 2'h0);
      busy <= (state != ST_IDLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Command execution
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= ST_IDLE;
      request_mask <= 8'h00;
      bad_cmd <= 1'b0;
      param_err <= 1'b0;
      done <= 1'b1;
      measure_after <= 1'b0;
      resp_valid <= 1'b0;
      resp_data <= 32'h0000_0000;
      resp_data2 <= 32'h0000_0000;
      resp_two <= 1'b0;
      input_kind_select <= 2'h0;
      voltage_config_select <= 2'h0;
      input_device_select <= 1'b0;
      coupling_select <= 1'b0;
      full_scale_code <= `ICS_RST_FS;
      amp_gain_code <= 4'h0;
      auto_gain <= 1'b0;
      notch_filter_select <= 2'h0;
      notch_line_50hz <= 1'b0;
      sample_rate_select <= 2'h0;
      op_mode <= 1'b0;
      reference_arrangement <= 2'h0;
      reference_source_select <= 2'h0;
      harmonic_number <= `ICS_RST_HARM;
      reference_phase_value <= 32'h0000_0000;
      auto_phase_start <= 1'b0;
    end else begin
      auto_phase_start <= 1'b0;
      if (resp_taken) begin
        resp_valid <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (cmd_valid) begin
            done <= 1'b0;
            bad_cmd <= 1'b0;
            param_err <= 1'b0;
            resp_two <= 1'b0;
            resp_data2 <= 32'h0000_0000;
            if (cmd_code > `ICS_CMD_LAST) begin
              bad_cmd <= 1'b1;
              done <= 1'b1;
            end else if (cmd_code == `ICS_CMD_AUTO_SENS || cmd_code == `ICS_CMD_AUTO_MEAS) begin
              measure_after <= (cmd_code == `ICS_CMD_AUTO_MEAS);
              state <= ST_SENS;
            end else if (!cmd_has_param) begin
              resp_valid <= 1'b1;
              done <= 1'b1;
              case (cmd_code)
                `ICS_CMD_MASK: resp_data <= {24'h00_0000, request_mask};
                `ICS_CMD_INPUT_KIND: resp_data <= {30'h0000_0000, input_kind_select};
                `ICS_CMD_VOLT_CFG: resp_data <= {30'h0000_0000, voltage_config_select};
                `ICS_CMD_IN_DEVICE: resp_data <= {31'h0000_0000, input_device_select};
                `ICS_CMD_COUPLING: resp_data <= {31'h0000_0000, coupling_select};
                `ICS_CMD_FULL_SCALE: resp_data <= {27'h000_0000, full_scale_code};
                `ICS_CMD_AMP_GAIN: resp_data <= {28'h000_0000, amp_gain_code};
                `ICS_CMD_AUTO_GAIN: resp_data <= {31'h0000_0000, auto_gain};
                `ICS_CMD_NOTCH: begin
                  resp_data <= {30'h0000_0000, notch_filter_select};
                  resp_data2 <= {31'h0000_0000, notch_line_50hz};
                  resp_two <= 1'b1;
                end
                `ICS_CMD_SAMPLE: resp_data <= {30'h0000_0000, sample_rate_select};
                `ICS_CMD_OP_MODE: resp_data <= {31'h0000_0000, op_mode};
                `ICS_CMD_REF_ARR: resp_data <= {30'h0000_0000, reference_arrangement};
                `ICS_CMD_REF_SRC: resp_data <= {30'h0000_0000, reference_source_select};
                `ICS_CMD_HARMONIC: resp_data <= {16'h0000, harmonic_number};
                default: resp_data <= reference_phase_value;
              endcase
            end else begin
              done <= 1'b1;
              case (cmd_code)
                `ICS_CMD_MASK: request_mask <= cmd_param[7:0];
                `ICS_CMD_INPUT_KIND:
                  if (in_range(cmd_param, 32'h0000_0000, `ICS_INPUT_KIND_MAX)) input_kind_select <= cmd_param[1:0];
                  else param_err <= 1'b1;
                `ICS_CMD_VOLT_CFG:
                  if (in_range(cmd_param, 32'h0000_0000, `ICS_VOLT_CFG_MAX)) voltage_config_select <= cmd_param[1:0];
                  else param_err <= 1'b1;
                `ICS_CMD_IN_DEVICE:
                  if (cmd_param[31:1] == 31'h0000_0000) input_device_select <= cmd_param[0];
                  else param_err <= 1'b1;
                `ICS_CMD_COUPLING:
                  if (cmd_param[31:1] == 31'h0000_0000) coupling_select <= cmd_param[0];
                  else param_err <= 1'b1;
                `ICS_CMD_FULL_SCALE:
                  if (!cmd_float && fs_ok) full_scale_code <= cmd_param[4:0];
                  else param_err <= 1'b1;
                `ICS_CMD_AMP_GAIN:
                  if (in_range(cmd_param, 32'h0000_0000, `ICS_GAIN_MAX)) amp_gain_code <= cmd_param[3:0];
                  else param_err <= 1'b1;
                `ICS_CMD_AUTO_GAIN:
                  if (cmd_param[31:1] == 31'h0000_0000) auto_gain <= cmd_param[0];
                  else param_err <= 1'b1;
                `ICS_CMD_NOTCH:
                  if (cmd_has_second && in_range(cmd_param, 32'h0000_0000, `ICS_NOTCH_MAX) &&
                      cmd_param2[31:1] == 31'h0000_0000) begin
                    notch_filter_select <= cmd_param[1:0];
                    notch_line_50hz <= cmd_param2[0];
                  end else param_err <= 1'b1;
                `ICS_CMD_SAMPLE:
                  if (in_range(cmd_param, 32'h0000_0000, `ICS_SAMPLE_MAX)) sample_rate_select <= cmd_param[1:0];
                  else param_err <= 1'b1;
                `ICS_CMD_OP_MODE:
                  if (cmd_param[31:1] == 31'h0000_0000) op_mode <= cmd_param[0];
                  else param_err <= 1'b1;
                `ICS_CMD_REF_ARR:
                  if (in_range(cmd_param, 32'h0000_0000, `ICS_REF_ARR_MAX)) reference_arrangement <= cmd_param[1:0];
                  else param_err <= 1'b1;
                `ICS_CMD_REF_SRC:
                  if (in_range(cmd_param, 32'h0000_0000, `ICS_REF_SRC_MAX)) reference_source_select <= cmd_param[1:0];
                  else param_err <= 1'b1;
                `ICS_CMD_HARMONIC:
                  if (in_range(cmd_param, `ICS_HARM_MIN, `ICS_HARM_MAX)) harmonic_number <= cmd_param[15:0];
                  else param_err <= 1'b1;
                default:
                  // Float form carries degrees, stored as given
                  if (cmd_float || abs_phase <= `ICS_PHASE_LIM) reference_phase_value <= cmd_param;
                  else param_err <= 1'b1;
              endcase
            end
          end
        end
        ST_SENS: begin
          // One range step per cycle until inside the window or at a range limit
          if (magnitude_pct > `ICS_AUTO_HIGH_PCT && full_scale_code < `ICS_FS_MAX) begin
            full_scale_code <= full_scale_code + 5'h01;
          end else if (magnitude_pct < `ICS_AUTO_LOW_PCT && full_scale_code > 5'h01 &&
                       !(input_kind_select == `ICS_INPUT_KIND_LOW_NOISE && full_scale_code <= `ICS_FS_LN_MIN)) begin
            full_scale_code <= full_scale_code - 5'h01;
          end else if (measure_after) begin
            auto_phase_start <= 1'b1;
            state <= ST_PHASE;
          end else begin
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_PHASE: begin
          if (auto_phase_done) begin
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

endmodule // ics_command

// ---- inc/ics_defines.vh ----
// Purpose: Constants for the instrument command and service-request block
// Assumes: Included by bare name from the design files
// Notes: Command codes and field layouts are local choices
`ifndef ICS_DEFINES_VH
`define ICS_DEFINES_VH

// Command codes on cmd_code
`define ICS_CMD_MASK 5'h00
`define ICS_CMD_INPUT_KIND 5'h01
`define ICS_CMD_VOLT_CFG 5'h02
`define ICS_CMD_IN_DEVICE 5'h03
`define ICS_CMD_COUPLING 5'h04
`define ICS_CMD_FULL_SCALE 5'h05
`define ICS_CMD_AUTO_SENS 5'h06
`define ICS_CMD_AUTO_MEAS 5'h07
`define ICS_CMD_AMP_GAIN 5'h08
`define ICS_CMD_AUTO_GAIN 5'h09
`define ICS_CMD_NOTCH 5'h0a
`define ICS_CMD_SAMPLE 5'h0b
`define ICS_CMD_OP_MODE 5'h0c
`define ICS_CMD_REF_ARR 5'h0d
`define ICS_CMD_REF_SRC 5'h0e
`define ICS_CMD_HARMONIC 5'h0f
`define ICS_CMD_PHASE 5'h10
`define ICS_CMD_LAST 5'h10

// Status byte bit positions
`define ICS_SB_DONE 0
`define ICS_SB_BAD_CMD 1
`define ICS_SB_PARAM_ERR 2
`define ICS_SB_UNLOCK 3
`define ICS_SB_OVERLOAD 4
`define ICS_SB_NEW_ADC 5
`define ICS_SB_RQS 6
`define ICS_SB_DATA 7

// Legal limits
`define ICS_INPUT_KIND_MAX 32'h0000_0002
`define ICS_INPUT_KIND_LOW_NOISE 2'h2
`define ICS_VOLT_CFG_MAX 32'h0000_0003
`define ICS_FS_MIN 32'h0000_0001
`define ICS_FS_MAX 32'h0000_001b
`define ICS_FS_LN_MIN 5'h07
`define ICS_GAIN_MAX 32'h0000_0009
`define ICS_NOTCH_MAX 32'h0000_0003
`define ICS_SAMPLE_MAX 32'h0000_0002
`define ICS_REF_ARR_MAX 32'h0000_0002
`define ICS_REF_SRC_MAX 32'h0000_0002
`define ICS_HARM_MIN 32'h0000_0001
`define ICS_HARM_MAX 32'h0000_ffff
`define ICS_PHASE_LIM 32'h0005_7e40

// Auto-range window in percent of full scale
`define ICS_AUTO_LOW_PCT 7'h1e
`define ICS_AUTO_HIGH_PCT 7'h5a

// Reset values
`define ICS_RST_FS 5'h12
`define ICS_RST_HARM 16'h0001

`endif

// ---- hw/ics_srq.v ----
// Purpose: Service-request generator from status byte and request mask
// Assumes: Status bits arrive as synchronous levels
// Notes: Bit 6 of the outgoing status byte mirrors the request line
`timescale 1ns/1ps
`include "ics_defines.vh"

module ics_srq (
  input wire clk,
  input wire nrst,
  input wire [7:0] status_raw,
  input wire [7:0] request_mask,
  output reg srq,
  output reg [7:0] status_byte
);

  wire [7:0] status_no_rqs;
  wire request;

  assign status_no_rqs = status_raw & 8'hbf;
  assign request = |(status_no_rqs & request_mask);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      srq <= 1'b0;
      status_byte <= 8'h00;
    end else begin
      srq <= request;
      status_byte <= status_no_rqs | ({7'h00, request} << `ICS_SB_RQS);
    end
  end

endmodule // ics_srq

// ---- verification/ics_command_props.sv ----
// Purpose: Port-level checks on the command block
// Assumes: Commands are taken only while busy is low
// Notes: Request mask is tracked from accepted mask writes
`timescale 1ns/1ps
`include "ics_defines.vh"

module ics_command_props (
  input wire clk,
  input wire nrst,
  input wire cmd_valid,
  input wire [4:0] cmd_code,
  input wire cmd_has_param,
  input wire cmd_float,
  input wire [31:0] cmd_param,
  input wire busy,
  input wire overload,
  input wire ref_unlock,
  input wire srq,
  input wire [7:0] status_byte,
  input wire [1:0] input_kind_select,
  input wire current_input,
  input wire [1:0] reference_arrangement,
  input wire extended_commands,
  input wire [4:0] full_scale_code,
  input wire [3:0] amp_gain_code,
  input wire auto_phase_start,
  input wire resp_valid,
  input wire [31:0] resp_data
);
  wire acc = cmd_valid && !busy;
  reg [7:0] mk;
  reg [2:0] zc;

  // Shadow mask and cycles spent at zero
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mk <= 8'h00;
      zc <= 3'h0;
    end else begin
      if (acc && cmd_code == `ICS_CMD_MASK && cmd_has_param)
        mk <= cmd_param[7:0];
      zc <= (mk != 8'h00) ? 3'h0 : ((zc == 3'h7) ? zc : zc + 3'h1);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  srq_bit_six_a: assert property (srq == status_byte[6])
    else $error("request line and status bit 6 differ");
  mask_raises_srq_a: assert property ((mk[4] && overload) [*5] |-> srq)
    else $error("masked overload gave no request");
  zero_mask_quiet_a: assert property (zc >= 3'h5 |-> !srq)
    else $error("request raised with zero mask");
  overload_bit_a: assert property (overload [*4] |-> status_byte[4])
    else $error("overload bit missing");
  unlock_bit_a: assert property (ref_unlock [*4] |-> status_byte[3])
    else $error("unlock bit missing");
  current_follow_a: assert property (current_input == ($past(input_kind_select) != 2'h0))
    else $error("current input does not follow input kind");
  extended_follow_a: assert property (extended_commands == ($past(reference_arrangement) != 2'h0))
    else $error("extended commands wrong");
  gain_keep_a: assert property ((acc && cmd_code == `ICS_CMD_AMP_GAIN && cmd_has_param
    && cmd_param > `ICS_GAIN_MAX) |=> $stable(amp_gain_code) ##[1:2] status_byte[2])
    else $error("bad gain not refused");
  fs_bounds_a: assert property (full_scale_code >= 5'h01 && full_scale_code <= 5'h1b)
    else $error("full scale out of range");
  fs_float_a: assert property ((acc && cmd_code == `ICS_CMD_FULL_SCALE && cmd_float)
    |=> $stable(full_scale_code)) else $error("float full scale write taken");
  bad_code_a: assert property ((acc && cmd_code > `ICS_CMD_LAST) |-> ##[2:3] status_byte[1])
    else $error("invalid command not flagged");
  gain_query_a: assert property ((acc && !cmd_has_param && cmd_code == `ICS_CMD_AMP_GAIN)
    |=> resp_valid && resp_data[3:0] == amp_gain_code) else $error("gain query answer wrong");
  phase_pulse_a: assert property (auto_phase_start |=> !auto_phase_start)
    else $error("phase start longer than one cycle");
endmodule // ics_command_props

bind ics_command ics_command_props ics_command_props_i (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
  .cmd_code(cmd_code), .cmd_has_param(cmd_has_param), .cmd_float(cmd_float), .cmd_param(cmd_param),
  .busy(busy), .overload(overload), .ref_unlock(ref_unlock), .srq(srq), .status_byte(status_byte),
  .input_kind_select(input_kind_select), .current_input(current_input), .resp_data(resp_data),
  .reference_arrangement(reference_arrangement), .extended_commands(extended_commands),
  .full_scale_code(full_scale_code), .amp_gain_code(amp_gain_code), .auto_phase_start(auto_phase_start),
  .resp_valid(resp_valid));

// ---- verification/ics_poll_ctrl.sv ----
// Purpose: Bus controller that serial-polls on a service request
// Assumes: One instrument on the bus
// Notes: Cause bits stay until the next poll
`timescale 1ns/1ps

module ics_poll_ctrl (
  input wire clk,
  input wire nrst,
  input wire srq,
  input wire [7:0] status_byte,
  output reg [7:0] cause
);
  always @(posedge clk or negedge nrst) begin
    if (!nrst)
      cause <= 8'h00;
    else if (srq && status_byte[6])
      cause <= status_byte & 8'hbf;
  end
endmodule // ics_poll_ctrl

// ---- verification/testbench.sv ----
// Purpose: Self-checking bench for the command block
// Assumes: Commands spaced by idle cycles
// Notes: Expected values come from legal ranges
`timescale 1ns/1ps
`include "ics_defines.vh"

module testbench;
  reg clk, nrst, cmd_valid, cmd_has_param, cmd_has_second, cmd_float, resp_taken;
  reg ref_unlock, overload, new_adc, auto_phase_done;
  reg [4:0] cmd_code;
  reg [31:0] cmd_param, cmd_param2;
  reg [6:0] magnitude_pct;
  wire resp_valid, resp_two, current_input, input_device_select, coupling_select, auto_gain;
  wire notch_line_50hz, op_mode, extended_commands, auto_phase_start, busy, srq;
  wire [31:0] resp_data, resp_data2, reference_phase_value;
  wire [1:0] input_kind_select, voltage_config_select, notch_filter_select, sample_rate_select;
  wire [1:0] reference_arrangement, reference_source_select;
  wire [4:0] full_scale_code;
  wire [3:0] amp_gain_code;
  wire [15:0] harmonic_number;
  wire [7:0] status_byte, cause;
  integer bad_count, cmp_count, seed, cyc, i, k, v, lo, hi, kind, phase_cnt;

  ics_command ics_command_i (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_has_param(cmd_has_param), .cmd_has_second(cmd_has_second), .cmd_float(cmd_float),
    .cmd_param(cmd_param), .cmd_param2(cmd_param2), .resp_taken(resp_taken), .ref_unlock(ref_unlock),
    .overload(overload), .new_adc(new_adc), .magnitude_pct(magnitude_pct),
    .auto_phase_done(auto_phase_done), .resp_valid(resp_valid), .resp_data(resp_data),
    .resp_data2(resp_data2), .resp_two(resp_two), .input_kind_select(input_kind_select),
    .current_input(current_input), .voltage_config_select(voltage_config_select),
    .input_device_select(input_device_select), .coupling_select(coupling_select),
    .full_scale_code(full_scale_code), .amp_gain_code(amp_gain_code), .auto_gain(auto_gain),
    .notch_filter_select(notch_filter_select), .notch_line_50hz(notch_line_50hz),
    .sample_rate_select(sample_rate_select), .op_mode(op_mode), .busy(busy), .srq(srq),
    .reference_arrangement(reference_arrangement), .extended_commands(extended_commands),
    .reference_source_select(reference_source_select), .harmonic_number(harmonic_number),
    .reference_phase_value(reference_phase_value), .auto_phase_start(auto_phase_start),
    .status_byte(status_byte));

  ics_poll_ctrl ics_poll_ctrl_i (.clk(clk), .nrst(nrst), .srq(srq), .status_byte(status_byte), .cause(cause));

  ////////////////////////////////////////////////////////////////////////////
  function [31:0] cur(input [4:0] c);
    case (c)
      `ICS_CMD_INPUT_KIND: cur = 32'(input_kind_select);
      `ICS_CMD_VOLT_CFG: cur = 32'(voltage_config_select);
      `ICS_CMD_IN_DEVICE: cur = 32'(input_device_select);
      `ICS_CMD_COUPLING: cur = 32'(coupling_select);
      `ICS_CMD_FULL_SCALE: cur = 32'(full_scale_code);
      `ICS_CMD_AMP_GAIN: cur = 32'(amp_gain_code);
      `ICS_CMD_AUTO_GAIN: cur = 32'(auto_gain);
      `ICS_CMD_SAMPLE: cur = 32'(sample_rate_select);
      `ICS_CMD_OP_MODE: cur = 32'(op_mode);
      `ICS_CMD_REF_ARR: cur = 32'(reference_arrangement);
      `ICS_CMD_REF_SRC: cur = 32'(reference_source_select);
      default: cur = 32'(harmonic_number);
    endcase
  endfunction

  function [31:0] hi_of(input [4:0] c);
    case (c)
      `ICS_CMD_VOLT_CFG: hi_of = `ICS_VOLT_CFG_MAX;
      `ICS_CMD_FULL_SCALE: hi_of = `ICS_FS_MAX;
      `ICS_CMD_AMP_GAIN: hi_of = `ICS_GAIN_MAX;
      `ICS_CMD_HARMONIC: hi_of = `ICS_HARM_MAX;
      `ICS_CMD_IN_DEVICE, `ICS_CMD_COUPLING, `ICS_CMD_AUTO_GAIN, `ICS_CMD_OP_MODE: hi_of = 32'h0000_0001;
      default: hi_of = `ICS_INPUT_KIND_MAX;
    endcase
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task cmd(input [4:0] c, input h, input [31:0] p);
    begin
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code <= c;
      cmd_has_param <= h;
      cmd_has_second <= h;
      cmd_param <= p;
      @(posedge clk);
      cmd_valid <= 1'b0;
      repeat (3) @(posedge clk);
      @(negedge clk);
    end
  endtask

  task take;
    begin
      @(posedge clk);
      resp_taken <= 1'b1;
      @(posedge clk);
      resp_taken <= 1'b0;
      @(negedge clk);
    end
  endtask

  task idle;
    begin
      i = 0;
      while (busy !== 1'b0 && i < 200) begin
        @(negedge clk);
        i = i + 1;
      end
      chk(i < 200, 1);
    end
  endtask

  task finish_test;
    begin
      $display("comparisons=%0d mismatches=%0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Far side acknowledges auto-phase one cycle after the start pulse
  always @(posedge clk) begin
    auto_phase_done <= auto_phase_start;
    phase_cnt = phase_cnt + (auto_phase_start === 1'b1);
    cyc = cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end

  initial begin
    {nrst, cmd_valid, cmd_has_param, cmd_has_second, cmd_float, resp_taken} = 6'h00;
    {ref_unlock, overload, new_adc, auto_phase_done} = 4'h0;
    {cmd_code, cmd_param, cmd_param2, magnitude_pct} = 76'h0;
    {bad_count, cmp_count, cyc, phase_cnt, kind} = 160'h0;
    seed = 11615;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(negedge clk);
    chk(status_byte, 8'h01);
    chk(full_scale_code, `ICS_RST_FS);
    chk(harmonic_number, `ICS_RST_HARM);
    chk(op_mode, 0);
    for (k = 1; k < 16; k = k + 1) if (k != 6 && k != 7 && k != 10) begin
      lo = (k == 5) ? ((kind == 2) ? 7 : 1) : ((k == 15) ? 1 : 0);
      hi = hi_of(k[4:0]);
      v = lo + ($unsigned($random(seed)) % (hi - lo + 1));
      if (k == 1) kind = v;
      cmd(k[4:0], 1, v);
      chk(cur(k[4:0]), v);
      chk(status_byte[2], 0);
      if (k == 13) chk(extended_commands, v != 0);
      cmd(k[4:0], 1, hi + 1);
      chk(cur(k[4:0]), v);
      chk(status_byte[2], 1);
      if (lo > 0) cmd(k[4:0], 1, lo - 1);
      chk(cur(k[4:0]), v);
      cmd(k[4:0], 0, 0);
      chk(resp_data, v);
      chk(status_byte[7], 1);
      take;
    end
    chk(current_input, kind != 0);
    cmd(5'h11, 1, 0);
    chk(status_byte[1], 1);
    cmd(`ICS_CMD_INPUT_KIND, 1, 2);
    cmd(`ICS_CMD_FULL_SCALE, 1, 6);
    chk(status_byte[2], 1);
    cmd(`ICS_CMD_FULL_SCALE, 1, 20);
    cmd_float <= 1'b1;
    cmd(`ICS_CMD_FULL_SCALE, 1, 9);
    chk(full_scale_code, 20);
    cmd_float <= 1'b0;
    magnitude_pct <= 7'h0a;
    cmd(`ICS_CMD_AUTO_SENS, 0, 0);
    idle;
    chk(full_scale_code, 7);
    magnitude_pct <= 7'h5f;
    cmd(`ICS_CMD_AUTO_MEAS, 0, 0);
    idle;
    chk(full_scale_code, 27);
    chk(phase_cnt, 1);
    magnitude_pct <= 7'h1e;
    cmd(`ICS_CMD_AUTO_SENS, 0, 0);
    idle;
    chk(full_scale_code, 27);
    cmd_param2 <= 32'h0000_0001;
    cmd(`ICS_CMD_NOTCH, 1, 3);
    cmd(`ICS_CMD_NOTCH, 1, 4);
    chk({notch_line_50hz, notch_filter_select, status_byte[2]}, 4'hf);
    cmd(`ICS_CMD_NOTCH, 0, 0);
    chk({resp_two, resp_data2[0], resp_data[1:0]}, 4'hf);
    take;
    cmd(`ICS_CMD_PHASE, 1, `ICS_PHASE_LIM);
    cmd(`ICS_CMD_PHASE, 1, -`ICS_PHASE_LIM - 1);
    chk(reference_phase_value, `ICS_PHASE_LIM);
    cmd(`ICS_CMD_PHASE, 1, -`ICS_PHASE_LIM);
    chk(reference_phase_value, 32'hfffa_81c0);
    cmd_float <= 1'b1;
    cmd(`ICS_CMD_PHASE, 1, 32'h0010_0000);
    chk(reference_phase_value, 32'h0010_0000);
    cmd_float <= 1'b0;
    cmd(`ICS_CMD_MASK, 1, 32'h0000_0010);
    {overload, ref_unlock, new_adc} <= 3'h7;
    repeat (6) @(negedge clk);
    chk({srq, status_byte[6:3]}, 5'h1f);
    chk(cause[4], 1);
    cmd(`ICS_CMD_MASK, 1, 0);
    repeat (6) @(negedge clk);
    chk({srq, status_byte[6], status_byte[4]}, 3'h1);
    // Mid-run reset must bring operating mode back to zero
    cmd(`ICS_CMD_OP_MODE, 1, 1);
    chk(op_mode, 1);
    @(posedge clk);
    nrst <= 1'b0;
    {overload, ref_unlock, new_adc} <= 3'h0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(negedge clk);
    chk({op_mode, status_byte}, 9'h001);
    finish_test;
  end
endmodule // testbench
